/* hdl/adcr_corr.sv */
`timescale 1ns/1ps
module adcr_corr (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [23:0] in_data,
  input wire logic [23:0] offset_cal,
  input wire logic [23:0] gain_cal,
  input wire logic format_select_bit,
  input wire logic unipolar_limit_bit,
  output logic out_valid,
  output logic [23:0] out_data
);
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } adcr_corr_st_t;

  adcr_corr_st_t s_reg, s_next;
  logic signed [24:0] diff;
  logic [24:0] gterm;
  logic signed [50:0] prod;
  logic signed [50:0] scaled;
  logic [23:0] sat;

  always_comb begin
    // offset applied is half the register, read as signed
    diff = 25'(signed'(in_data)) - 25'(signed'(offset_cal) >>> 1);
    // unsigned register, unity at 0x800000
    gterm = 25'({1'b0, gain_cal} >> 1) + adcr_pkg::GAIN_HALF;
    prod = 51'(diff) * 51'(signed'({1'b0, gterm}));
    scaled = prod >>> adcr_pkg::PROD_SHIFT;
    if (scaled > 51'(signed'(adcr_pkg::POS_MAX))) begin
      sat = adcr_pkg::POS_MAX;
    end else if (scaled < 51'(signed'(adcr_pkg::NEG_MIN))) begin
      sat = adcr_pkg::NEG_MIN;
    end else begin
      sat = scaled[23:0];
    end
    if (unipolar_limit_bit && sat[23]) begin
      sat = 24'h000000;
    end
    s_next.valid = in_valid;
    s_next.data = s_reg.data;
    if (in_valid) begin
      s_next.data = {sat[23] ^ format_select_bit, sat[22:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign out_valid = s_reg.valid;
  assign out_data = s_reg.data;

  property p_unipolar;
    @(posedge clk) disable iff (!rstn)
      out_valid && $past(unipolar_limit_bit) |-> out_data[23] == $past(format_select_bit);
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("unipolar result went negative");

  property p_format;
    @(posedge clk) disable iff (!rstn)
      in_valid && in_data == 24'h000000 && offset_cal == 24'h000000 |=>
        out_data == {$past(format_select_bit), 23'h000000};
  endproperty
  a_format: assert property (p_format) else $error("zero coded wrongly");
endmodule

/* hdl/adcr_pkg.sv */
// Contract
// - latest outcome held in 24-bit conversion_result_reg, msb in top byte.
// - new outcome loaded into conversion_result_reg just before result_ready_n falls.
// - host reads within data period minus 24 clocks, else next outcome overwrites.
// - result_ready_n forced high before each update, unless a read is in progress.
// - result coded two's complement or offset binary per format_select_bit.
// - unipolar_limit_bit restricts stored results to unipolar values.
// - 24-bit offset_cal_reg drives an offset correction on every outcome.
// - offset_cal_reg readable and writable by the host.
// - offset_cal_reg is two's complement whatever format_select_bit says.
// - applied offset is a linear function of offset_cal_reg, not the value itself.
// - 24-bit gain_cal_reg drives a full-scale correction on every outcome.
// - gain_cal_reg readable and writable by the host.
// - gain_cal_reg is unsigned binary whatever format_select_bit says.
// - applied gain is a linear function of gain_cal_reg, not the value itself.
// - operating_mode_field starts calibrations; temporary modes revert to normal when done.
// - result_ready_n low means result ready, high means none new.
package adcr_pkg;
  localparam logic [1:0] SEL_RESULT = 2'h0;
  localparam logic [1:0] SEL_OFFSET = 2'h1;
  localparam logic [1:0] SEL_GAIN = 2'h2;
  localparam logic [1:0] BYTE_BOT = 2'h0;
  localparam logic [1:0] BYTE_MID = 2'h1;
  localparam logic [1:0] BYTE_TOP = 2'h2;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF = 3'h1;
  localparam logic [2:0] MODE_SYS_OFF = 3'h2;
  localparam logic [2:0] MODE_SYS_FS = 3'h3;
  localparam logic [2:0] MODE_PSEUDO = 3'h4;
  localparam logic [2:0] MODE_BACKGROUND = 3'h5;
  // guard before overwrite, in master clock periods (clk is the master clock)
  localparam int GUARD_MCLK = 24;
  localparam int CLK_PER_MCLK = 1;
  localparam logic [4:0] GUARD_CYC = 5'(GUARD_MCLK * CLK_PER_MCLK);
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h800000;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  localparam logic [24:0] GAIN_HALF = 25'h0400000;
  localparam logic [23:0] GAIN_CAL_TOP = 24'hffffff;
  localparam int PROD_SHIFT = 23;
  localparam logic [23:0] POS_MAX = 24'h7fffff;
  localparam logic [23:0] NEG_MIN = 24'h800000;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_OFF = 2'b01,
    CAL_GAIN = 2'b10
  } adcr_cal_t;
endpackage

/* hdl/adcr_regs.sv */
`timescale 1ns/1ps
module adcr_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic raw_valid,
  input wire logic [23:0] raw_data,
  input wire logic format_select_bit,
  input wire logic unipolar_limit_bit,
  input wire logic [2:0] operating_mode_field,
  input wire logic read_active,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [1:0] byte_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic result_ready_n,
  output logic mode_revert,
  output logic cal_busy
);
  typedef struct packed {
    logic [23:0] result;
    logic [23:0] offset_cal;
    logic [23:0] gain_cal;
    logic [23:0] pend;
    logic [4:0] guard;
    logic guard_on;
    logic announce;
    logic ready_n;
    logic [7:0] rdata;
    logic revert;
    logic busy;
    logic both;
    logic bg_phase;
    logic [2:0] mode_seen;
    adcr_pkg::adcr_cal_t cal;
  } adcr_regs_st_t;

  adcr_regs_st_t s_reg, s_next;
  logic corr_in_valid;
  logic corr_valid;
  logic [23:0] corr_data;
  logic load;
  logic bg_cal_sample;
  logic take_new;

  function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] sel);
    unique case (sel)
      adcr_pkg::BYTE_TOP: get_byte = v[23:16];
      adcr_pkg::BYTE_MID: get_byte = v[15:8];
      adcr_pkg::BYTE_BOT: get_byte = v[7:0];
      default: get_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] sel,
                                           input logic [7:0] b);
    put_byte = v;
    unique case (sel)
      adcr_pkg::BYTE_TOP: put_byte[23:16] = b;
      adcr_pkg::BYTE_MID: put_byte[15:8] = b;
      adcr_pkg::BYTE_BOT: put_byte[7:0] = b;
      default: put_byte = v;
    endcase
  endfunction

  // background mode spends every other sample on an offset measurement
  assign bg_cal_sample = operating_mode_field == adcr_pkg::MODE_BACKGROUND && s_reg.bg_phase;
  assign corr_in_valid = raw_valid && s_reg.cal == adcr_pkg::CAL_IDLE && !bg_cal_sample;
  assign load = s_reg.guard_on && s_reg.guard == 5'h00 && !read_active;
  assign take_new = corr_valid && !read_active;

  adcr_corr i_adcr_corr (
    .clk(clk),
    .rstn(rstn),
    .in_valid(corr_in_valid),
    .in_data(raw_data),
    .offset_cal(s_reg.offset_cal),
    .gain_cal(s_reg.gain_cal),
    .format_select_bit(format_select_bit),
    .unipolar_limit_bit(unipolar_limit_bit),
    .out_valid(corr_valid),
    .out_data(corr_data)
  );

  always_comb begin
    s_next = s_reg;
    s_next.revert = 1'b0;
    s_next.announce = 1'b0;
    if (reg_rd) begin
      unique case (reg_sel)
        adcr_pkg::SEL_RESULT: begin
          s_next.rdata = get_byte(s_reg.result, byte_sel);
          if (byte_sel == adcr_pkg::BYTE_BOT) begin
            s_next.ready_n = 1'b1;
          end
        end
        adcr_pkg::SEL_OFFSET: s_next.rdata = get_byte(s_reg.offset_cal, byte_sel);
        adcr_pkg::SEL_GAIN: s_next.rdata = get_byte(s_reg.gain_cal, byte_sel);
        default: s_next.rdata = 8'h00;
      endcase
    end
    if (reg_wr && reg_sel == adcr_pkg::SEL_OFFSET) begin
      s_next.offset_cal = put_byte(s_reg.offset_cal, byte_sel, reg_wdata);
    end
    if (reg_wr && reg_sel == adcr_pkg::SEL_GAIN) begin
      s_next.gain_cal = put_byte(s_reg.gain_cal, byte_sel, reg_wdata);
    end
    // a result arriving mid-read is dropped so the host never sees torn bytes
    if (take_new) begin
      s_next.pend = corr_data;
      s_next.guard_on = 1'b1;
      s_next.guard = adcr_pkg::GUARD_CYC - 5'h01;
      s_next.ready_n = 1'b1;
    end else if (s_reg.guard_on && read_active) begin
      s_next.guard_on = 1'b0;
    end else if (s_reg.guard_on) begin
      s_next.guard = s_reg.guard - 5'h01;
      if (load) begin
        s_next.result = s_reg.pend;
        s_next.guard_on = 1'b0;
        s_next.announce = 1'b1;
      end
    end
    // a newer value arriving now keeps ready high for its own guard
    if (s_reg.announce && !take_new) begin
      s_next.ready_n = 1'b0;
    end
    if (raw_valid && operating_mode_field == adcr_pkg::MODE_BACKGROUND
        && s_reg.cal == adcr_pkg::CAL_IDLE) begin
      s_next.bg_phase = !s_reg.bg_phase;
      if (s_reg.bg_phase) begin
        s_next.offset_cal = {raw_data[22:0], 1'b0};
      end
    end
    // calibration captures win over a host write in the same cycle
    unique case (s_reg.cal)
      adcr_pkg::CAL_IDLE: begin
        if (operating_mode_field != s_reg.mode_seen) begin
          s_next.mode_seen = operating_mode_field;
          s_next.both = 1'b0;
          unique case (operating_mode_field)
            adcr_pkg::MODE_SELF, adcr_pkg::MODE_PSEUDO: begin
              s_next.cal = adcr_pkg::CAL_OFF;
              s_next.both = 1'b1;
            end
            adcr_pkg::MODE_SYS_OFF: s_next.cal = adcr_pkg::CAL_OFF;
            adcr_pkg::MODE_SYS_FS: s_next.cal = adcr_pkg::CAL_GAIN;
            default: s_next.cal = adcr_pkg::CAL_IDLE;
          endcase
        end
      end
      adcr_pkg::CAL_OFF: begin
        if (raw_valid) begin
          s_next.offset_cal = {raw_data[22:0], 1'b0};
          s_next.cal = s_reg.both ? adcr_pkg::CAL_GAIN : adcr_pkg::CAL_IDLE;
          s_next.revert = !s_reg.both;
        end
      end
      adcr_pkg::CAL_GAIN: begin
        if (raw_valid) begin
          // first-order reciprocal: full-scale sample of 0x7fffff gives unity
          s_next.gain_cal = adcr_pkg::GAIN_CAL_TOP - raw_data;
          s_next.cal = adcr_pkg::CAL_IDLE;
          s_next.revert = 1'b1;
        end
      end
      default: s_next.cal = adcr_pkg::CAL_IDLE;
    endcase
    s_next.busy = s_next.cal != adcr_pkg::CAL_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.result <= adcr_pkg::RESULT_RST;
      s_reg.offset_cal <= adcr_pkg::OFFSET_RST;
      s_reg.gain_cal <= adcr_pkg::GAIN_RST;
      s_reg.ready_n <= 1'b1;
      s_reg.mode_seen <= adcr_pkg::MODE_NORMAL;
      s_reg.cal <= adcr_pkg::CAL_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign result_ready_n = s_reg.ready_n;
  assign mode_revert = s_reg.revert;
  assign cal_busy = s_reg.busy;

  logic [5:0] hold_cnt;
  always_ff @(posedge clk) begin
    if (!rstn || !s_reg.guard_on || take_new) begin
      hold_cnt <= 6'h00;
    end else begin
      hold_cnt <= hold_cnt + 6'h01;
    end
  end

  property p_ann_low;
    @(posedge clk) disable iff (!rstn) load ##1 !take_new |=> !result_ready_n;
  endproperty
  a_ann_low: assert property (p_ann_low) else $error("ready not low after load");

  property p_fall_after_load;
    @(posedge clk) disable iff (!rstn) $fell(result_ready_n) |-> $past(load, 2);
  endproperty
  a_fall_after_load: assert property (p_fall_after_load) else $error("ready fell, no load");

  property p_guard_high;
    @(posedge clk) disable iff (!rstn) s_reg.guard_on |-> result_ready_n;
  endproperty
  a_guard_high: assert property (p_guard_high) else $error("ready low during update");

  property p_guard_span;
    @(posedge clk) disable iff (!rstn) load |-> hold_cnt == 6'(adcr_pkg::GUARD_CYC - 5'h01);
  endproperty
  a_guard_span: assert property (p_guard_span) else $error("overwrite guard length wrong");

  property p_read_stable;
    @(posedge clk) disable iff (!rstn) read_active |=> $stable(s_reg.result);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("result changed mid-read");

  property p_read_clear;
    @(posedge clk) disable iff (!rstn)
      reg_rd && reg_sel == adcr_pkg::SEL_RESULT && byte_sel == adcr_pkg::BYTE_BOT
      && !s_reg.announce |=> result_ready_n;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("ready not cleared by read");

  property p_offset_wr;
    @(posedge clk) disable iff (!rstn)
      reg_wr && reg_sel == adcr_pkg::SEL_OFFSET && byte_sel == adcr_pkg::BYTE_MID
      && s_reg.cal == adcr_pkg::CAL_IDLE && !raw_valid |=> s_reg.offset_cal[15:8] == $past(reg_wdata);
  endproperty
  a_offset_wr: assert property (p_offset_wr) else $error("offset byte not written");

  property p_gain_rd;
    @(posedge clk) disable iff (!rstn)
      reg_rd && reg_sel == adcr_pkg::SEL_GAIN && byte_sel == adcr_pkg::BYTE_TOP
      |=> reg_rdata == $past(s_reg.gain_cal[23:16]);
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain top byte misread");

  property p_revert;
    @(posedge clk) disable iff (!rstn) mode_revert |-> $past(cal_busy) && !cal_busy;
  endproperty
  a_revert: assert property (p_revert) else $error("revert without calibration");

  c_announce: cover property (@(posedge clk) disable iff (!rstn) $fell(result_ready_n));
  c_abort: cover property (@(posedge clk) disable iff (!rstn) s_reg.guard_on && read_active);
  c_self_cal: cover property (@(posedge clk) disable iff (!rstn)
    s_reg.cal == adcr_pkg::CAL_GAIN && s_reg.both ##[1:1000] mode_revert);
endmodule

/* tb/adcr_host.sv */
`timescale 1ns/1ps
module adcr_host (
  input wire logic clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [1:0] reg_sel,
  output logic [1:0] byte_sel,
  output logic [7:0] reg_wdata,
  output logic read_active,
  output logic format_select_bit,
  output logic unipolar_limit_bit,
  output logic [2:0] operating_mode_field
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_sel = 2'h0;
    byte_sel = 2'h0;
    reg_wdata = 8'h00;
    read_active = 1'b0;
    format_select_bit = 1'b0;
    unipolar_limit_bit = 1'b0;
    operating_mode_field = 3'h0;
  end
  // one strobe per byte, top byte first; gap models a slow host
  task automatic xfer(input logic w, input logic [1:0] s, input logic [23:0] v, input int gap);
    for (int b = 2; b >= 0; b--) begin
      @(posedge clk);
      reg_rd <= !w;
      reg_wr <= w;
      reg_sel <= s;
      byte_sel <= 2'(b);
      reg_wdata <= v[b*8 +: 8];
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      // released data must not look like the last byte
      reg_wdata <= ~v[b*8 +: 8];
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

/* tb/tb_adcr_regs.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_adcr_regs;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic raw_valid = 1'b0;
  logic [23:0] raw_data = 24'h000000;
  logic [23:0] cur_off, cur_gain, r, r2, last_res;
  logic reg_rd, reg_wr, read_active, format_select_bit, unipolar_limit_bit;
  logic [1:0] reg_sel, byte_sel;
  logic [7:0] reg_wdata, reg_rdata;
  logic [7:0] exp_b;
  logic [2:0] operating_mode_field;
  logic result_ready_n, mode_revert, cal_busy;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  always #5 clk = ~clk;
  adcr_host i_host(.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .byte_sel(byte_sel), .reg_wdata(reg_wdata), .read_active(read_active),
    .format_select_bit(format_select_bit), .unipolar_limit_bit(unipolar_limit_bit),
    .operating_mode_field(operating_mode_field));
  adcr_regs i_adcr_regs(.clk(clk), .rstn(rstn), .raw_valid(raw_valid), .raw_data(raw_data),
    .format_select_bit(format_select_bit), .unipolar_limit_bit(unipolar_limit_bit),
    .operating_mode_field(operating_mode_field), .read_active(read_active),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .byte_sel(byte_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_ready_n(result_ready_n),
    .mode_revert(mode_revert), .cal_busy(cal_busy));
  // pop once: the compare macro evaluates its expected value twice
  always @(posedge clk) begin
    if (rd_d) begin
      exp_b = exp_q.pop_front();
      `CHK(reg_rdata, exp_b)
    end
    rd_d <= reg_rd;
  end
  task finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rd24(input logic [1:0] s, input logic [23:0] e);
    exp_q.push_back(e[23:16]);
    exp_q.push_back(e[15:8]);
    exp_q.push_back(e[7:0]);
    i_host.xfer(1'b0, s, 24'h000000, $urandom % 3);
  endtask
  task setcal(input logic [23:0] o, input logic [23:0] g);
    i_host.xfer(1'b1, adcr_pkg::SEL_OFFSET, o, 0);
    i_host.xfer(1'b1, adcr_pkg::SEL_GAIN, g, 1);
    cur_off = o;
    cur_gain = g;
  endtask
  task ticks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task pulse(input logic [23:0] v);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_data <= v;
    @(posedge clk);
    raw_valid <= 1'b0;
    raw_data <= ~v;
  endtask
  // independent reference of the correction path
  function automatic logic [23:0] model(input logic [23:0] v, input logic f, input logic u);
    longint d;
    logic [23:0] y;
    d = longint'($signed(v)) - (longint'($signed(cur_off)) >>> 1);
    d = (d * (longint'(cur_gain) / 2 + 4194304)) >>> 23;
    if (d > 8388607) d = 8388607;
    if (d < -8388608) d = -8388608;
    if (u && d < 0) d = 0;
    y = d[23:0];
    y[23] = y[23] ^ f;
    return y;
  endfunction
  initial begin
    #500000;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(66));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    cur_off = 24'h000000;
    cur_gain = 24'h800000;
    rd24(adcr_pkg::SEL_RESULT, 24'h000000);
    rd24(adcr_pkg::SEL_OFFSET, cur_off);
    rd24(adcr_pkg::SEL_GAIN, cur_gain);
    i_host.xfer(1'b1, 2'h3, 24'($urandom), 0);
    rd24(2'h3, 24'h000000);
    setcal(24'($urandom), 24'($urandom));
    rd24(adcr_pkg::SEL_OFFSET, cur_off);
    rd24(adcr_pkg::SEL_GAIN, cur_gain);
    $display("test regs done");
    setcal(24'h000000, 24'h800000);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) setcal(24'($urandom), 24'($urandom));
      if (i == 6) setcal(24'h000000, 24'hffffff);
      @(posedge clk);
      i_host.format_select_bit <= i[1];
      i_host.unipolar_limit_bit <= i[2];
      // zero input with zero offset shows the bare coding of zero
      r = (i == 7) ? 24'h7fffff : (i == 2) ? 24'h000000 : 24'($urandom);
      last_res = model(r, i[1], i[2]);
      pulse(r);
      ticks(2);
      `CHK(result_ready_n, 1'b1)
      ticks(23);
      `CHK(result_ready_n, 1'b1)
      ticks(1);
      `CHK(result_ready_n, 1'b0)
      // even passes leave the result unread so the next one overwrites it
      if (i[0]) begin
        rd24(adcr_pkg::SEL_RESULT, last_res);
        ticks(1);
        `CHK(result_ready_n, 1'b1)
      end
    end
    $display("test conv done");
    @(posedge clk);
    i_host.read_active <= 1'b1;
    pulse(24'($urandom));
    ticks(30);
    `CHK(result_ready_n, 1'b1)
    rd24(adcr_pkg::SEL_RESULT, last_res);
    @(posedge clk);
    i_host.read_active <= 1'b0;
    $display("test drop done");
    for (int m = 1; m <= 4; m++) begin
      @(posedge clk);
      i_host.operating_mode_field <= 3'(m);
      ticks(2);
      `CHK(cal_busy, 1'b1)
      r = 24'($urandom);
      r2 = 24'($urandom);
      pulse(r);
      if (m != 3) cur_off = {r[22:0], 1'b0};
      else cur_gain = 24'hffffff - r;
      if (m == 1 || m == 4) begin
        ticks(1);
        pulse(r2);
        cur_gain = 24'hffffff - r2;
      end
      // revert stands one cycle: look right after the capturing edge first
      n = 0;
      #1;
      while (mode_revert !== 1'b1 && n < 20) begin
        ticks(1);
        n++;
      end
      `CHK(mode_revert, 1'b1)
      `CHK(cal_busy, 1'b0)
      if (mode_revert !== 1'b1) break;
      @(posedge clk);
      i_host.operating_mode_field <= 3'h0;
      ticks(3);
      rd24(adcr_pkg::SEL_OFFSET, cur_off);
      rd24(adcr_pkg::SEL_GAIN, cur_gain);
    end
    $display("test cal done");
    // background: first sample converts, second one refreshes the offset only
    @(posedge clk);
    i_host.operating_mode_field <= 3'h5;
    ticks(2);
    r = 24'($urandom);
    last_res = model(r, format_select_bit, unipolar_limit_bit);
    pulse(r);
    ticks(26);
    `CHK(result_ready_n, 1'b0)
    rd24(adcr_pkg::SEL_RESULT, last_res);
    r2 = 24'($urandom);
    pulse(r2);
    ticks(30);
    `CHK(result_ready_n, 1'b1)
    cur_off = {r2[22:0], 1'b0};
    rd24(adcr_pkg::SEL_OFFSET, cur_off);
    $display("test bg done");
    ticks(4);
    finish_test();
  end
endmodule
